// [ssp_regs.vh]
/*
  Register offsets, field positions and reset values of the serial
  peripheral port. Assumes inclusion by bare name from the same folder.
*/
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

`define SSP_ADDR_DATA      8'h21
`define SSP_ADDR_CTRL      8'h22
`define SSP_ADDR_CSR       8'h23
`define SSP_ADDR_IRQ_STAT  8'h24
`define SSP_ADDR_IRQ_MASK  8'h25

`define SSP_CR_IRQ_EN      7
`define SSP_CR_PORT_EN     6
`define SSP_CR_DIV_EN      5
`define SSP_CR_MASTER      4
`define SSP_CR_CPOL        3
`define SSP_CR_CPHA        2

`define SSP_CSR_DONE       7
`define SSP_CSR_WCOL       6
`define SSP_CSR_OVR        5
`define SSP_CSR_MODE_FAULT_FLAG       4
`define SSP_CSR_OUT_DIS    2
`define SSP_CSR_SOFT_MGMT  1
`define SSP_CSR_INT_LEVEL  0

`define SSP_CR_RESET       8'h00
`define SSP_CSR_RESET      8'h00
`define SSP_BITS_PER_BYTE  4'h8

`endif

// [ssp_pin_sync.v]
/*
  Three-stage synchroniser for one pin level.
  Assumes the pin is asynchronous to ref_clk; output changes once the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // Pin and clean level
  input  wire pin,
  input  wire reset_level,
  output wire level
);
  reg s1;
  reg s2;
  reg s3;
  reg held;

  // Agreement shows at once: a registered level would eat a whole
  // half period of the fastest usable link clock
  assign level = (s2 == s3) ? s3 : held;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      s1   <= reset_level;
      s2   <= reset_level;
      s3   <= reset_level;
      held <= reset_level;
    end else begin
      s1   <= pin;
      s2   <= s1;
      s3   <= s2;
      held <= level;
    end
  end
endmodule // ssp_pin_sync
`default_nettype wire

// [ssp_port.v]
/*
  Byte-wide synchronous serial port, master or slave, with data,
  control and control/status registers plus an interrupt status/mask pair.
  Assumes a single-cycle register port on ref_clk and an external
  serial partner whose pins are asynchronous to ref_clk.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"

// How it works
// RULE1: Slave select low while master sets the mode fault flag.
// RULE2: Mode fault raises the interrupt only when interrupt enable is set.
// RULE3: Mode fault clears by control access while set, then control write.
// RULE4: Software writes zero to status bit 3; it always reads zero.
// RULE5: Output disable releases MOSI or MISO; else driven when port enabled.
// RULE6: Soft management ignores the select pin, uses the internal level bit.
// RULE7: Internal level bit zero selects the slave, one deselects it.
// RULE8: In master mode each data write starts a one-byte duplex transfer.
// RULE9: On the last serial clock, set done and copy shift register to buffer.
// RULE10: While done is set, data writes are ignored until status is read.
// RULE11: Data writes load the shift register directly, no transmit buffer.
// RULE12: Data reads return the receive buffer, not the shift register.
// RULE13: Master mode fault clears port enable and master select.
// RULE14: Done sets per transfer; clears by status access then data access.
// RULE15: With interrupt enable, request interrupt on done, fault or overrun.
module ssp_port (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Interrupt
  output wire       irq,
  // Serial pins
  input  wire       sck_in,
  output wire       sck_out,
  output wire       sck_oe,
  input  wire       mosi_in,
  output wire       mosi_out,
  output wire       mosi_oe,
  input  wire       miso_in,
  output wire       miso_out,
  output wire       miso_oe,
  input  wire       ss_n_in
);
  reg  [7:0] ctrl;
  reg        done_flag;
  reg        wcol_flag;
  reg        ovr_flag;
  reg        mode_fault_flag_flag;
  reg  [2:0] csr_cfg;
  reg  [7:0] shifter;
  reg  [7:0] rx_buf;
  reg  [2:0] irq_stat;
  reg  [2:0] irq_mask;
  reg        csr_seen;
  reg        mode_fault_flag_seen;
  reg        busy;
  reg  [3:0] bit_cnt;
  reg        sck_lvl;
  reg        sample_bit;
  reg  [6:0] div_cnt;
  reg        sck_prev;
  reg        tail;
  reg        primed;
  wire       sck_s;
  wire       mosi_s;
  wire       miso_s;
  wire       ss_pin_s;

  ssp_pin_sync u_sck (.ref_clk(ref_clk), .rstn(rstn), .pin(sck_in),
                      .reset_level(1'b0), .level(sck_s));
  ssp_pin_sync u_mosi (.ref_clk(ref_clk), .rstn(rstn), .pin(mosi_in),
                       .reset_level(1'b0), .level(mosi_s));
  ssp_pin_sync u_miso (.ref_clk(ref_clk), .rstn(rstn), .pin(miso_in),
                       .reset_level(1'b0), .level(miso_s));
  ssp_pin_sync u_ss (.ref_clk(ref_clk), .rstn(rstn), .pin(ss_n_in),
                     .reset_level(1'b1), .level(ss_pin_s));

  wire port_en   = ctrl[`SSP_CR_PORT_EN];
  wire master    = ctrl[`SSP_CR_MASTER];
  wire cpol      = ctrl[`SSP_CR_CPOL];
  wire cpha      = ctrl[`SSP_CR_CPHA];
  wire out_dis   = csr_cfg[`SSP_CSR_OUT_DIS];
  wire soft_mgmt = csr_cfg[`SSP_CSR_SOFT_MGMT];
  // Select pin resets to deselected, so no fault follows reset
  wire ss_level  = soft_mgmt ? csr_cfg[`SSP_CSR_INT_LEVEL] : ss_pin_s;  // RULE6 RULE7
  wire selected  = ~ss_level;  // RULE7

  wire wr_data = wr && addr == `SSP_ADDR_DATA;
  wire rd_data = rd && addr == `SSP_ADDR_DATA;
  wire wr_ctrl = wr && addr == `SSP_ADDR_CTRL;
  wire acc_ctrl = (wr || rd) && addr == `SSP_ADDR_CTRL;
  wire wr_csr  = wr && addr == `SSP_ADDR_CSR;
  wire rd_csr  = rd && addr == `SSP_ADDR_CSR;
  wire acc_csr = (wr || rd) && addr == `SSP_ADDR_CSR;

  wire fault   = port_en && master && selected && rstn;  // RULE1
  wire data_ok = wr_data && !(done_flag && !csr_seen);  // RULE10
  wire start   = data_ok && master && port_en && !busy;  // RULE8

  // Baud divider: rate code from enable bit and two low control bits
  function [6:0] half_period;
    input [2:0] code;
    begin
      case (code)
        3'h4:    half_period = 7'h01;
        3'h0:    half_period = 7'h03;
        3'h1:    half_period = 7'h07;
        3'h6:    half_period = 7'h0f;
        3'h2:    half_period = 7'h1f;
        3'h3:    half_period = 7'h3f;
        default: half_period = 7'h03;
      endcase
    end
  endfunction

  // Tail half period brings the clock back to idle after the last capture
  wire tick = master && (busy || tail) && div_cnt == 7'h00;

  // Slave edges from the synchronised clock pin
  wire sck_rise = sck_s && !sck_prev;
  wire sck_fall = !sck_s && sck_prev;
  wire lead_edge  = (cpol ? sck_fall : sck_rise);
  wire trail_edge = (cpol ? sck_rise : sck_fall);
  wire s_sample = !master && port_en && selected && (cpha ? trail_edge : lead_edge);
  wire s_shift  = !master && port_en && selected && (cpha ? lead_edge : trail_edge);

  // Master: toggle sck_lvl each tick; sample on capture, shift on other
  wire m_capture = tick && (sck_lvl == cpha);
  wire m_shift   = tick && (sck_lvl != cpha);
  wire in_bit    = master ? miso_s : mosi_s;
  wire last_bit  = bit_cnt == `SSP_BITS_PER_BYTE - 4'h1;
  wire finish    = (master ? m_capture : s_sample) && last_bit && busy;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl <= `SSP_CR_RESET;
      csr_cfg <= 3'h0;
      done_flag <= 1'b0;
      wcol_flag <= 1'b0;
      ovr_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
      csr_seen <= 1'b0;
      mode_fault_flag_seen <= 1'b0;
      shifter <= 8'h00;
      rx_buf <= 8'h00;
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      sck_lvl <= 1'b0;
      sample_bit <= 1'b0;
      div_cnt <= 7'h00;
      sck_prev <= 1'b0;
      tail <= 1'b0;
      primed <= 1'b0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      sck_prev <= sck_s;
      if (wr_ctrl)
        ctrl <= wdata;
      if (fault) begin
        ctrl[`SSP_CR_PORT_EN] <= 1'b0;  // RULE13
        ctrl[`SSP_CR_MASTER]  <= 1'b0;  // RULE13
        busy <= 1'b0;
        tail <= 1'b0;
      end
      if (wr_csr)
        csr_cfg <= wdata[2:0];  // RULE4
      // Mode fault: set wins over the clearing write
      if (acc_ctrl && mode_fault_flag_flag)
        mode_fault_flag_seen <= 1'b1;
      if (fault)
        mode_fault_flag_flag <= 1'b1;  // RULE1
      else if (wr_ctrl && mode_fault_flag_seen) begin
        mode_fault_flag_flag <= 1'b0;  // RULE3
        mode_fault_flag_seen <= 1'b0;
      end
      // Done and write collision, two-step clears; overrun clears on status read
      if (acc_csr && done_flag)
        csr_seen <= 1'b1;
      if (rd_csr)
        ovr_flag <= 1'b0;
      if ((rd_data || wr_data) && csr_seen && !finish) begin
        done_flag <= 1'b0;  // RULE14
        wcol_flag <= 1'b0;
        csr_seen <= 1'b0;
      end
      if (wr_data && busy)
        wcol_flag <= 1'b1;
      if (data_ok && !busy) begin
        shifter <= wdata;  // RULE11
        bit_cnt <= 4'h0;
        busy <= master ? port_en : 1'b0;
      end
      if (start) begin
        div_cnt <= half_period({ctrl[`SSP_CR_DIV_EN], ctrl[1:0]});
        sck_lvl <= 1'b0;
        tail <= 1'b0;
        primed <= 1'b0;
      end else if (tick) begin
        div_cnt <= half_period({ctrl[`SSP_CR_DIV_EN], ctrl[1:0]});
        sck_lvl <= ~sck_lvl;
      end else if (div_cnt != 7'h00)
        div_cnt <= div_cnt - 7'h01;
      if (tick && !busy)
        tail <= 1'b0;
      if (!master && port_en && selected && !busy && (s_sample || s_shift))
        busy <= 1'b1;
      if (!master && !selected) begin
        bit_cnt <= 4'h0;
        primed <= 1'b0;
      end
      // No shift before a first capture, else phase 1 drops the top bit
      if (m_capture || s_sample) begin
        sample_bit <= in_bit;
        primed <= 1'b1;
      end
      if ((m_shift || s_shift) && (busy || !master) && primed) begin
        shifter <= {shifter[6:0], sample_bit};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (finish) begin
        busy <= 1'b0;
        bit_cnt <= 4'h0;
        // Shifter held so the data pin stays put on the last clock edge
        tail <= master && !cpha;
        primed <= 1'b0;
        if (done_flag)
          ovr_flag <= 1'b1;
        else begin
          done_flag <= 1'b1;  // RULE9 RULE14
          rx_buf <= {shifter[6:0], in_bit};  // RULE9
        end
      end
      // Sticky interrupt status: done, fault, overrun; write one clears
      irq_stat <= (irq_stat & ~(wr && addr == `SSP_ADDR_IRQ_STAT ? wdata[2:0] : 3'h0))
                  | {finish & done_flag, fault, finish & ~done_flag};
      if (wr && addr == `SSP_ADDR_IRQ_MASK)
        irq_mask <= wdata[2:0];
    end
  end

  // Flag-level request gated by enable, plus sticky masked events
  wire flag_req = ctrl[`SSP_CR_IRQ_EN] && (done_flag || mode_fault_flag_flag || ovr_flag);  // RULE2 RULE15
  assign irq = flag_req || (ctrl[`SSP_CR_IRQ_EN] && |(irq_stat & irq_mask));

  always @(posedge ref_clk) begin
    if (!rstn)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `SSP_ADDR_DATA:     rdata <= rx_buf;  // RULE12
        `SSP_ADDR_CTRL:     rdata <= ctrl;
        `SSP_ADDR_CSR:      rdata <= {done_flag, wcol_flag, ovr_flag, mode_fault_flag_flag,
                                      1'b0, csr_cfg};
        `SSP_ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat};
        `SSP_ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask};
        default:            rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end

  // Pin drive
  wire data_out = shifter[7];
  assign sck_out  = master ? (sck_lvl ^ cpol) : 1'b0;
  assign sck_oe   = port_en && master;
  assign mosi_out = data_out;
  assign mosi_oe  = port_en && master && !out_dis;  // RULE5
  assign miso_out = data_out;
  assign miso_oe  = port_en && !master && selected && !out_dis;  // RULE5
endmodule // ssp_port
`default_nettype wire

// [ssp_port_props.sv]
/* Checker on the ports of ssp_port.
   Assumes the bind below and a single ref_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module ssp_port_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Pin enables
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_csr_rd;
    rd && addr == 8'h23;
  endsequence
  sequence s_dat_rd;
    rd && addr == 8'h21;
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd && (addr > 8'h25 || addr < 8'h21) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_csr_bit3: assert property (s_csr_rd |=> !rdata[3])
    else $error("status bit 3 set");
  a_out_dis: assert property (wr && addr == 8'h23 && wdata[2] |=> !mosi_oe && !miso_oe)
    else $error("data output not released");
  a_mosi_master: assert property (mosi_oe |-> sck_oe)
    else $error("mosi driven outside master");
  a_miso_slave: assert property (miso_oe |-> !sck_oe)
    else $error("miso driven in master");
  a_fault_drop: assert property (sck_oe && wr && addr == 8'h23 && wdata[1:0] == 2'b10
    |-> ##[1:3] !sck_oe) else $error("fault kept master");
  a_soft_ignore: assert property (sck_oe && wr && addr == 8'h23 && wdata[1:0] == 2'b11
    |=> sck_oe[*8]) else $error("soft select not honoured");
  a_done_cleared: assert property (s_csr_rd ##2 s_dat_rd ##2 s_csr_rd |=> !rdata[7])
    else $error("done flag not cleared");
endmodule // ssp_port_props
bind ssp_port ssp_port_props u_props (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe));
`default_nettype wire

// [ssp_slave_model.sv]
/* Behavioural serial slave: clock idle low, capture on rising edge.
   Assumes the bench drives select and the next byte to send. */
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
  // Serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output wire logic       miso,
  // Bench side
  input  wire logic [7:0] tx,
  output var  logic [7:0] rx,
  output var  int         edges
);
  logic [7:0] sh = 8'h00;
  initial rx = 8'h00;
  initial edges = 0;
  // Deselected line shows the inverse bit, never a stale copy
  assign miso = sel_n ^ sh[7];
  // One process loads on select and on the fall that closes a byte
  always @(negedge sel_n or negedge sck)
    if (!sel_n) sh <= (edges % 8 == 0) ? tx : {sh[6:0], sh[7]};
  always @(posedge sck) if (!sel_n) begin
    rx    <= {rx[6:0], mosi};
    edges <= edges + 1;
  end
endmodule // ssp_slave_model
`default_nettype wire

// [ssp_port_tb_top.sv]
/* Self-checking bench for ssp_port with a serial slave model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ssp_port_tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        ss_n_in = 1'b1;
  logic        sel_n   = 1'b1;
  logic        pend    = 1'b0;
  logic [7:0]  tx, d, t;
  logic [15:0] n;
  logic [15:0] exp_q[$];
  wire  [7:0]  rdata, rx;
  wire         irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, miso;
  int          mismatches = 0, check_count = 0, edges, seed = 32'h369c1c49;
  ssp_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .sck_in(sck_out), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_out), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
  ssp_slave_model u_slave (.sck(sck_out), .mosi(mosi_out), .sel_n(sel_n), .tx(tx),
    .miso(miso), .rx(rx), .edges(edges));
  always #50 ref_clk = ~ref_clk;
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    pend <= rd;
    if (pend) begin
      n = exp_q.pop_front();
      `CHK(rdata & n[15:8], n[7:0])
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back({m, e & m});
    @(posedge ref_clk);
    rd   <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tx = 8'($random(seed));
    repeat (16) @(posedge ref_clk);
    rstn  <= 1'b1;
    sel_n <= 1'b0;
    rreg(8'h23, 8'h00, 8'hff);
    rreg(8'h22, 8'h00, 8'hff);
    rreg(8'h30, 8'h00, 8'hff);
    wreg(8'h23, 8'h00);
    wreg(8'h22, 8'hd0);
    for (int k = 1; k <= 2; k++) begin
      t = tx;
      d = 8'($random(seed));
      wreg(8'h21, d);
      tx <= 8'($random(seed));
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      wreg(8'h21, ~d);
      repeat (100) @(posedge ref_clk);
      `CHK(edges, 8 * k)
      `CHK(rx, d)
      rreg(8'h23, 8'h80, 8'h80);
      rreg(8'h21, t, 8'hff);
      rreg(8'h23, 8'h00, 8'h80);
    end
    wreg(8'h23, 8'h04);
    `CHK(mosi_oe, 1'b0)
    wreg(8'h23, 8'h03);
    `CHK(mosi_oe, 1'b1)
    @(posedge ref_clk) ss_n_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rreg(8'h23, 8'h00, 8'h10);
    wreg(8'h23, 8'h02);
    repeat (4) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rreg(8'h23, 8'h10, 8'h10);
    rreg(8'h22, 8'h80, 8'hd0);
    rreg(8'h24, 8'h02, 8'h02);
    wreg(8'h22, 8'h00);
    `CHK(irq, 1'b0)
    rreg(8'h23, 8'h00, 8'h10);
    // Enable alone, flags clear: only the sticky path can raise irq
    wreg(8'h22, 8'h80);
    wreg(8'h25, 8'h02);
    `CHK(irq, 1'b1)
    wreg(8'h25, 8'h00);
    `CHK(irq, 1'b0)
    wreg(8'h25, 8'h02);
    wreg(8'h24, 8'hff);
    `CHK(irq, 1'b0)
    rreg(8'h24, 8'h00, 8'h03);
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
  initial begin
    #(60000 * 100);
    mismatches++;
    stop_test();
  end
endmodule // ssp_port_tb_top
`default_nettype wire
